// File: rtl/cbx_exec.sv
// Overview of operation
// RULE_01: bit xor: carry becomes carry xor bit
// RULE_02: inverted xor: carry xor inverted bit
// RULE_03: bit load copies selected bit to carry
// RULE_04: inverted load copies inverted bit to carry
// RULE_05: bit store writes carry, others unchanged
// RULE_06: inverted store writes inverted carry to bit
// RULE_07: branch only when condition true; always/never
// RULE_08: carry and zero based branch conditions
// RULE_09: overflow, negative and signed branch conditions
// RULE_10: jump, two calls saving return, return
// RULE_11: trap starts exception handling
// RULE_12: exception return restores interrupted point
// RULE_13: sleep enters power-down state
// RULE_14: control load from register, memory, immediate; here control load only takes the command immediate
// RULE_15: control store to register or memory
// RULE_16: memory control transfers are word, upper byte
// RULE_17: control and with immediate byte
// RULE_18: control or with immediate byte
// RULE_19: control xor with immediate byte
// RULE_20: no-op advances pc by two only
// RULE_21: block move skips zero, copies, increments
// RULE_22: byte/word count; next follows last byte
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbx_exec (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cbx_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cbx_pkg::DATA_W-1:0] pwdata,
  output var  logic [cbx_pkg::DATA_W-1:0] prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  output var  logic                       sleep_mode,
  output var  logic                       busy
);
  import cbx_pkg::*;

  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    case (a)
      CMD_OFS, OPERAND_OFS, CCR_OFS, EXR_OFS, PC_OFS, TARGET_OFS, SRC_OFS,
      DST_OFS, COUNT_OFS, STATUS_OFS, RET_OFS, EXC_PC_OFS, MEM_ADDR_OFS,
      MEM_DATA_OFS: reg_known = 1'b1;
      default:      reg_known = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] eff_count(input logic word, input logic [15:0] c);
    eff_count = word ? c : {8'h00, c[7:0]};
  endfunction

  logic [7:0]        ccr_reg;
  logic [7:0]        exr_reg;
  logic [7:0]        exc_ccr_reg;
  logic [15:0]       operand_reg;
  logic [PC_W-1:0]   pc_reg;
  logic [PC_W-1:0]   target_reg;
  logic [PC_W-1:0]   ret_reg;
  logic [PC_W-1:0]   exc_pc_reg;
  logic [PC_W-1:0]   src_reg;
  logic [PC_W-1:0]   dst_reg;
  logic [15:0]       cnt_reg;
  logic              word_mode_reg;
  logic              taken_reg;
  logic              illegal_reg;
  logic [MEM_AW-1:0] mem_addr_reg;
  cbx_state_type     state_reg;
  logic [7:0]        mem [MEM_DEPTH];

  cbx_cmd_type       cmd;
  logic              access;
  logic              wr_acc;
  logic              start;
  logic              sel_bit;
  logic              cond_true;
  logic [7:0]        ctl_cur;
  logic [7:0]        ctl_next;
  logic              ctl_write;
  logic [PC_W-1:0]   pc_step;
  logic [PC_W-1:0]   rel_target;
  logic [15:0]       start_cnt;
  logic [15:0]       rem_cnt;
  logic              move_last;
  logic              is_move;
  logic [DATA_W-1:0] rd_mux;

  assign cmd        = cbx_cmd_type'(pwdata);
  assign access     = psel & penable & pready;
  assign wr_acc     = access & pwrite & ~pslverr;
  // commands are dropped while a block move runs or the core sleeps
  assign start      = wr_acc && (paddr == CMD_OFS) && (state_reg == st_idle) && !sleep_mode;
  assign sel_bit    = operand_reg[cmd.bitno];
  assign ctl_cur    = cmd.sel_exr ? exr_reg : ccr_reg;
  assign pc_step    = pc_reg + PC_STEP;
  assign rel_target = pc_step + {{(PC_W-16){cmd.imm[15]}}, cmd.imm};
  assign is_move    = (cmd.op == block_move_byte_count_op) || (cmd.op == block_move_word_count_op);
  assign start_cnt  = eff_count(cmd.op == block_move_word_count_op, cnt_reg); // RULE_22
  assign rem_cnt    = eff_count(word_mode_reg, cnt_reg); // RULE_22
  assign move_last  = (state_reg == st_move) && (rem_cnt == 16'h0001);

  cbx_cond_eval u_cond (
    .cond  (cmd.cond),
    .flags (ccr_reg),
    .taken (cond_true)
  );

  always_comb begin
    ctl_write = 1'b1;
    case (cmd.op)
      control_load_op: ctl_next = cmd.word ? cmd.imm[15:8] : cmd.imm[7:0]; // RULE_14 RULE_16
      control_and_op:  ctl_next = ctl_cur & cmd.imm[7:0]; // RULE_17
      control_or_op:   ctl_next = ctl_cur | cmd.imm[7:0]; // RULE_18
      control_xor_op:  ctl_next = ctl_cur ^ cmd.imm[7:0]; // RULE_19
      default: begin
        ctl_next  = ctl_cur;
        ctl_write = 1'b0;
      end
    endcase
  end

  // flags and extended control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_reg <= CTL_RST;
      exr_reg <= CTL_RST;
    end else if (wr_acc && paddr == CCR_OFS) begin
      ccr_reg <= pwdata[7:0];
    end else if (wr_acc && paddr == EXR_OFS) begin
      exr_reg <= pwdata[7:0];
    end else if (start) begin
      if (ctl_write && cmd.sel_exr) begin
        exr_reg <= ctl_next;
      end else if (ctl_write) begin
        ccr_reg <= ctl_next;
      end
      case (cmd.op)
        bit_xor_carry_op:      ccr_reg[C_BIT] <= ccr_reg[C_BIT] ^ sel_bit; // RULE_01
        bit_inv_xor_carry_op:  ccr_reg[C_BIT] <= ccr_reg[C_BIT] ^ ~sel_bit; // RULE_02
        bit_load_carry_op:     ccr_reg[C_BIT] <= sel_bit; // RULE_03
        bit_inv_load_carry_op: ccr_reg[C_BIT] <= ~sel_bit; // RULE_04
        exception_return_op:   ccr_reg <= exc_ccr_reg; // RULE_12
        default: ;
      endcase
    end
  end

  // 16-bit operand stands in for a general register or memory operand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_reg <= 16'h0000;
    end else if (wr_acc && paddr == OPERAND_OFS) begin
      operand_reg <= pwdata[15:0];
    end else if (start) begin
      case (cmd.op)
        bit_store_carry_op:     operand_reg[cmd.bitno] <= ccr_reg[C_BIT]; // RULE_05
        bit_inv_store_carry_op: operand_reg[cmd.bitno] <= ~ccr_reg[C_BIT]; // RULE_06
        control_store_op: begin
          if (cmd.word) begin
            operand_reg <= {ctl_cur, 8'h00}; // RULE_15 RULE_16
          end else begin
            operand_reg[7:0] <= ctl_cur; // RULE_15
          end
        end
        default: ;
      endcase
    end
  end

  // program flow: pc, return point, exception frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg      <= PC_RST;
      target_reg  <= PC_RST;
      ret_reg     <= PC_RST;
      exc_pc_reg  <= PC_RST;
      exc_ccr_reg <= CTL_RST;
      taken_reg   <= 1'b0;
    end else begin
      if (wr_acc && paddr == TARGET_OFS) begin
        target_reg <= pwdata[PC_W-1:0];
      end
      if (move_last) begin
        pc_reg <= pc_step; // RULE_22
      end else if (wr_acc && paddr == PC_OFS) begin
        pc_reg <= pwdata[PC_W-1:0];
      end else if (start) begin
        case (cmd.op)
          cond_branch_op: begin
            pc_reg    <= cond_true ? rel_target : pc_step; // RULE_07
            taken_reg <= cond_true;
          end
          jump_op: pc_reg <= target_reg; // RULE_10
          relative_call_op: begin
            ret_reg <= pc_step; // RULE_10
            pc_reg  <= rel_target;
          end
          absolute_call_op: begin
            ret_reg <= pc_step; // RULE_10
            pc_reg  <= target_reg;
          end
          return_sub_op: pc_reg <= ret_reg; // RULE_10
          trap_op: begin
            exc_pc_reg  <= pc_step; // RULE_11
            exc_ccr_reg <= ccr_reg;
            pc_reg      <= TRAP_VEC_BASE + {{(PC_W-4){1'b0}}, cmd.imm[1:0], 2'b00};
          end
          exception_return_op: pc_reg <= exc_pc_reg; // RULE_12
          block_move_byte_count_op, block_move_word_count_op: begin
            // pc holds during the move and steps on its last byte
            if (start_cnt == 16'h0000) begin
              pc_reg <= pc_step; // RULE_21
            end
          end
          default: pc_reg <= pc_step; // RULE_20
        endcase
      end
    end
  end

  // block move sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= st_idle;
      busy          <= 1'b0;
      src_reg       <= PC_RST;
      dst_reg       <= PC_RST;
      cnt_reg       <= 16'h0000;
      word_mode_reg <= 1'b0;
    end else if (state_reg == st_move) begin
      src_reg <= src_reg + PTR_STEP; // RULE_21
      dst_reg <= dst_reg + PTR_STEP; // RULE_21
      if (word_mode_reg) begin
        cnt_reg <= cnt_reg - 16'h0001; // RULE_22
      end else begin
        cnt_reg[7:0] <= cnt_reg[7:0] - 8'h01; // RULE_22
      end
      if (move_last) begin
        state_reg <= st_idle;
        busy      <= 1'b0;
      end
    end else if (start && is_move && start_cnt != 16'h0000) begin
      state_reg     <= st_move; // RULE_21
      busy          <= 1'b1;
      word_mode_reg <= (cmd.op == block_move_word_count_op);
    end else if (wr_acc) begin
      case (paddr)
        SRC_OFS:   src_reg <= pwdata[PC_W-1:0];
        DST_OFS:   dst_reg <= pwdata[PC_W-1:0];
        COUNT_OFS: cnt_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // small data memory; pointers wrap on its low address bits
  always_ff @(posedge pclk) begin
    if (state_reg == st_move) begin
      mem[dst_reg[MEM_AW-1:0]] <= mem[src_reg[MEM_AW-1:0]]; // RULE_21
    end else if (wr_acc && paddr == MEM_DATA_OFS) begin
      mem[mem_addr_reg] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_reg <= '0;
    end else if (wr_acc && paddr == MEM_ADDR_OFS) begin
      mem_addr_reg <= pwdata[MEM_AW-1:0];
    end
  end

  // sleep and illegal-command status; a new event wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_mode  <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (start && cmd.op == sleep_op) begin
        sleep_mode <= 1'b1; // RULE_13
      end else if (wr_acc && paddr == STATUS_OFS && pwdata[STAT_SLEEP]) begin
        sleep_mode <= 1'b0;
      end
      if (start && cmd.op > block_move_word_count_op) begin
        illegal_reg <= 1'b1;
      end else if (wr_acc && paddr == STATUS_OFS && pwdata[STAT_ILLEGAL]) begin
        illegal_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    case (paddr)
      OPERAND_OFS:  rd_mux[15:0] = operand_reg;
      CCR_OFS:      rd_mux[7:0] = ccr_reg;
      EXR_OFS:      rd_mux[7:0] = exr_reg;
      PC_OFS:       rd_mux[PC_W-1:0] = pc_reg;
      TARGET_OFS:   rd_mux[PC_W-1:0] = target_reg;
      SRC_OFS:      rd_mux[PC_W-1:0] = src_reg;
      DST_OFS:      rd_mux[PC_W-1:0] = dst_reg;
      COUNT_OFS:    rd_mux[15:0] = cnt_reg;
      RET_OFS:      rd_mux[PC_W-1:0] = ret_reg;
      EXC_PC_OFS:   rd_mux[PC_W-1:0] = exc_pc_reg;
      MEM_ADDR_OFS: rd_mux[MEM_AW-1:0] = mem_addr_reg;
      MEM_DATA_OFS: rd_mux[7:0] = mem[mem_addr_reg];
      STATUS_OFS: begin
        rd_mux[STAT_BUSY]    = busy;
        rd_mux[STAT_SLEEP]   = sleep_mode;
        rd_mux[STAT_TAKEN]   = taken_reg;
        rd_mux[STAT_ILLEGAL] = illegal_reg;
      end
      default: ;
    endcase
  end

  // read data is sampled in the setup cycle, so every access has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~reg_known(paddr);
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_BIT_XOR: assert property ( // RULE_01
    start && cmd.op == bit_xor_carry_op
    |=> ccr_reg[C_BIT] == ($past(ccr_reg[C_BIT]) ^ $past(sel_bit)))
    else $error("bit xor carry wrong");
  AST_BIT_INV_XOR: assert property ( // RULE_02
    start && cmd.op == bit_inv_xor_carry_op
    |=> ccr_reg[C_BIT] != ($past(ccr_reg[C_BIT]) ^ $past(sel_bit)))
    else $error("inverted bit xor carry wrong");
  AST_BIT_LOAD: assert property ( // RULE_03
    start && cmd.op == bit_load_carry_op |=> ccr_reg[C_BIT] == $past(sel_bit))
    else $error("bit load carry wrong");
  AST_BIT_STORE: assert property ( // RULE_05
    start && cmd.op == bit_store_carry_op
    |=> $countones(operand_reg ^ $past(operand_reg)) <= 1
        && operand_reg[$past(cmd.bitno)] == $past(ccr_reg[C_BIT])
        && ccr_reg[C_BIT] == $past(ccr_reg[C_BIT]))
    else $error("bit store touched other bits");
  AST_BRANCH: assert property ( // RULE_07
    start && cmd.op == cond_branch_op
    |=> pc_reg == ($past(cond_true) ? $past(rel_target) : $past(pc_step)))
    else $error("branch target wrong");
  AST_NOP: assert property ( // RULE_20
    start && cmd.op == no_operation_op
    |=> pc_reg == $past(pc_step) && $stable(ccr_reg) && $stable(exr_reg))
    else $error("no-op changed state");
  AST_CTL_AND: assert property ( // RULE_17
    start && cmd.op == control_and_op && !cmd.sel_exr
    |=> ccr_reg == $past(ctl_next) && $stable(exr_reg))
    else $error("control and wrong");
  AST_SLEEP: assert property ( // RULE_13
    start && cmd.op == sleep_op |=> sleep_mode ##1 sleep_mode || $past(wr_acc))
    else $error("sleep not entered");
  AST_MOVE_SKIP: assert property ( // RULE_21
    start && is_move && start_cnt == 16'h0000
    |=> state_reg == st_idle && pc_reg == $past(pc_step))
    else $error("zero count move not skipped");
  AST_MOVE_END: assert property ( // RULE_22
    move_last |=> state_reg == st_idle && !busy && pc_reg == $past(pc_step))
    else $error("move did not end on last byte");

endmodule // cbx_exec
`default_nettype wire

// File: common/cbx_pkg.sv
package cbx_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PC_W      = 24;
  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;

  localparam logic [ADDR_W-1:0] CMD_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] OPERAND_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] CCR_OFS      = 8'h08;
  localparam logic [ADDR_W-1:0] EXR_OFS      = 8'h0c;
  localparam logic [ADDR_W-1:0] PC_OFS       = 8'h10;
  localparam logic [ADDR_W-1:0] TARGET_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] SRC_OFS      = 8'h18;
  localparam logic [ADDR_W-1:0] DST_OFS      = 8'h1c;
  localparam logic [ADDR_W-1:0] COUNT_OFS    = 8'h20;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h24;
  localparam logic [ADDR_W-1:0] RET_OFS      = 8'h28;
  localparam logic [ADDR_W-1:0] EXC_PC_OFS   = 8'h2c;
  localparam logic [ADDR_W-1:0] MEM_ADDR_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] MEM_DATA_OFS = 8'h34;

  // flag positions in the condition code register
  localparam int C_BIT = 0;
  localparam int V_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int N_BIT = 3;

  // status register bits
  localparam int STAT_BUSY    = 0;
  localparam int STAT_SLEEP   = 1;
  localparam int STAT_TAKEN   = 2;
  localparam int STAT_ILLEGAL = 3;

  localparam logic [7:0]      CTL_RST       = 8'h00;
  localparam logic [PC_W-1:0] PC_RST        = 24'h000000;
  localparam logic [PC_W-1:0] PC_STEP       = 24'h000002;
  localparam logic [PC_W-1:0] PTR_STEP      = 24'h000001;
  localparam logic [PC_W-1:0] TRAP_VEC_BASE = 24'h000020;

  typedef enum logic [4:0] {
    no_operation_op          = 5'h00,
    bit_xor_carry_op         = 5'h01,
    bit_inv_xor_carry_op     = 5'h02,
    bit_load_carry_op        = 5'h03,
    bit_inv_load_carry_op    = 5'h04,
    bit_store_carry_op       = 5'h05,
    bit_inv_store_carry_op   = 5'h06,
    cond_branch_op           = 5'h07,
    jump_op                  = 5'h08,
    relative_call_op         = 5'h09,
    absolute_call_op         = 5'h0a,
    return_sub_op            = 5'h0b,
    trap_op                  = 5'h0c,
    exception_return_op      = 5'h0d,
    sleep_op                 = 5'h0e,
    control_load_op          = 5'h0f,
    control_store_op         = 5'h10,
    control_and_op           = 5'h11,
    control_or_op            = 5'h12,
    control_xor_op           = 5'h13,
    block_move_byte_count_op = 5'h14,
    block_move_word_count_op = 5'h15
  } cbx_op_type;

  typedef enum logic [3:0] {
    branch_always_op      = 4'h0,
    branch_never_op       = 4'h1,
    branch_high_op        = 4'h2,
    branch_low_same_op    = 4'h3,
    branch_carry_clear_op = 4'h4,
    branch_carry_set_op   = 4'h5,
    branch_not_equal_op   = 4'h6,
    branch_equal_op       = 4'h7,
    branch_ovf_clear_op   = 4'h8,
    branch_ovf_set_op     = 4'h9,
    branch_plus_op        = 4'ha,
    branch_minus_op       = 4'hb,
    branch_ge_signed_op   = 4'hc,
    branch_lt_signed_op   = 4'hd,
    branch_gt_signed_op   = 4'he,
    branch_le_signed_op   = 4'hf
  } cbx_cond_type;

  typedef struct packed {
    logic [15:0]  imm;
    logic [1:0]   spare;
    cbx_cond_type cond;
    logic         sel_exr;
    logic         word;
    logic [2:0]   bitno;
    logic [4:0]   op;
  } cbx_cmd_type;

  typedef enum logic {
    st_idle = 1'b0,
    st_move = 1'b1
  } cbx_state_type;

endpackage

// File: rtl/cbx_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module cbx_cond_eval (
  input  wire cbx_pkg::cbx_cond_type cond,
  input  wire logic [7:0]            flags,
  output var  logic                  taken
);
  import cbx_pkg::*;

  logic c;
  logic v;
  logic z;
  logic n;

  always_comb begin
    c = flags[C_BIT];
    v = flags[V_BIT];
    z = flags[Z_BIT];
    n = flags[N_BIT];
    case (cond)
      branch_always_op:      taken = 1'b1; // RULE_07
      branch_never_op:       taken = 1'b0; // RULE_07
      branch_high_op:        taken = ~(c | z); // RULE_08
      branch_low_same_op:    taken = c | z; // RULE_08
      branch_carry_clear_op: taken = ~c; // RULE_08
      branch_carry_set_op:   taken = c; // RULE_08
      branch_not_equal_op:   taken = ~z; // RULE_08
      branch_equal_op:       taken = z; // RULE_08
      branch_ovf_clear_op:   taken = ~v; // RULE_09
      branch_ovf_set_op:     taken = v; // RULE_09
      branch_plus_op:        taken = ~n; // RULE_09
      branch_minus_op:       taken = n; // RULE_09
      branch_ge_signed_op:   taken = ~(n ^ v); // RULE_09
      branch_lt_signed_op:   taken = n ^ v; // RULE_09
      branch_gt_signed_op:   taken = ~(z | (n ^ v)); // RULE_09
      branch_le_signed_op:   taken = z | (n ^ v); // RULE_09
      default:               taken = 1'b0;
    endcase
  end

endmodule // cbx_cond_eval
`default_nettype wire

// File: tb/cbx_apb_master.sv
`timescale 1ns/1ps
`default_nettype none
module cbx_apb_master (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic hung = 1'b0;

  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end

  // an idle cycle after each transfer keeps every signal to one update per edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) hung = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // cbx_apb_master
`default_nettype wire

// File: tb/test_cpu_bitop_branch_sysctl_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_bitop_branch_sysctl_exec;
  import cbx_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, sleep_mode, busy, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          bad_count = 0;
  int          total_checks = 0;

  always #10 pclk = ~pclk;

  cbx_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cbx_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .busy(busy));

  task automatic wrap_up();
    if (u_mst.hung) bad_count++;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_mst.xfer(1'b1, a, d, q, e);
    if (u_mst.hung) wrap_up();
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    u_mst.xfer(1'b0, a, 32'h0, q, e);
    if (u_mst.hung) wrap_up();
    chk(nm, q, exp);
  endtask

  function automatic logic [31:0] cmd(input logic [4:0] op, input logic [2:0] b,
      input logic w, input logic s, input logic [3:0] c, input logic [15:0] imm);
    return {imm, 2'b00, c, s, w, b, op};
  endfunction

  task automatic cx(input logic [4:0] op, input logic s, input logic w, input logic [15:0] imm);
    wr(CMD_OFS, cmd(op, 3'h0, w, s, 4'h0, imm));
  endtask

  // nz tells whether the move must show busy right after the command
  task automatic mv(input logic [4:0] op, input logic nz);
    int n;
    n = 0;
    cx(op, 1'b0, 1'b0, 16'h0);
    chk("busy", {31'h0, busy}, {31'h0, nz});
    while (busy !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (busy !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic mc(input logic [7:0] a, input logic [7:0] exp);
    wr(MEM_ADDR_OFS, {24'h0, a});
    rc("mem", MEM_DATA_OFS, {24'h0, exp});
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc("ccr", CCR_OFS, 32'h0);
    rc("exr", EXR_OFS, 32'h0);
    rc("pc", PC_OFS, 32'h0);
    for (int op = 1; op <= 6; op++) for (int k = 0; k < 2; k++) begin
      logic [2:0] bn;
      logic [7:0] o, c;
      bn = 3'(op + k);
      o = 8'h96;
      c = 8'(8'hf0 | k);
      wr(OPERAND_OFS, {24'h0, o});
      wr(CCR_OFS, {24'h0, c});
      wr(CMD_OFS, cmd(5'(op), bn, 1'b0, 1'b0, 4'h0, 16'h0));
      case (op)
        1: c[C_BIT] = c[C_BIT] ^ o[bn];
        2: c[C_BIT] = c[C_BIT] ^ ~o[bn];
        3: c[C_BIT] = o[bn];
        4: c[C_BIT] = ~o[bn];
        5: o[bn] = c[C_BIT];
        default: o[bn] = ~c[C_BIT];
      endcase
      rc("ccr", CCR_OFS, {24'h0, c});
      rc("operand", OPERAND_OFS, {24'h0, o});
    end
    for (int f = 0; f < 16; f++) for (int cd = 0; cd < 16; cd++) begin
      logic [3:0] fl;
      logic [7:0] v;
      logic       x;
      fl = 4'(f);
      x = fl[N_BIT] ^ fl[V_BIT];
      v = {fl[Z_BIT] | x, x, fl[N_BIT], fl[V_BIT], fl[Z_BIT], fl[C_BIT],
           fl[C_BIT] | fl[Z_BIT], 1'b0};
      wr(CCR_OFS, 32'(f));
      wr(PC_OFS, 32'h100);
      wr(CMD_OFS, cmd(cond_branch_op, 3'h0, 1'b0, 1'b0, 4'(cd), 16'hfff0));
      rc("branch pc", PC_OFS, (v[cd >> 1] == cd[0]) ? 32'hf2 : 32'h102);
    end
    for (int s = 0; s < 2; s++) begin
      logic [7:0] ro;
      ro = (s == 1) ? EXR_OFS : CCR_OFS;
      wr(ro, 32'h5c);
      wr(OPERAND_OFS, 32'h0);
      cx(control_and_op, 1'(s), 1'b0, 16'h00f3);
      rc("and", ro, 32'h50);
      cx(control_or_op, 1'(s), 1'b0, 16'h0021);
      rc("or", ro, 32'h71);
      cx(control_xor_op, 1'(s), 1'b0, 16'h00ff);
      rc("xor", ro, 32'h8e);
      cx(control_store_op, 1'(s), 1'b0, 16'h0);
      rc("store", OPERAND_OFS, 32'h8e);
      cx(control_store_op, 1'(s), 1'b1, 16'h0);
      rc("store", OPERAND_OFS, 32'h8e00);
      cx(control_load_op, 1'(s), 1'b0, 16'h3ca5);
      rc("load", ro, 32'ha5);
      cx(control_load_op, 1'(s), 1'b1, 16'h3ca5);
      rc("load", ro, 32'h3c);
    end
    wr(CCR_OFS, 32'h0b);
    wr(PC_OFS, 32'h200);
    cx(no_operation_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h202);
    rc("ccr", CCR_OFS, 32'h0b);
    wr(PC_OFS, 32'h300);
    wr(TARGET_OFS, 32'h440);
    cx(absolute_call_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h440);
    rc("ret", RET_OFS, 32'h302);
    cx(relative_call_op, 1'b0, 1'b0, 16'h0010);
    rc("pc", PC_OFS, 32'h452);
    rc("ret", RET_OFS, 32'h442);
    cx(return_sub_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h442);
    cx(jump_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h440);
    wr(CCR_OFS, 32'h05);
    cx(trap_op, 1'b0, 1'b0, 16'h0002);
    rc("pc", PC_OFS, 32'h28);
    rc("exc pc", EXC_PC_OFS, 32'h442);
    wr(CCR_OFS, 32'h80);
    cx(exception_return_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h442);
    rc("ccr", CCR_OFS, 32'h05);
    wr(PC_OFS, 32'h500);
    cx(sleep_op, 1'b0, 1'b0, 16'h0);
    chk("sleep", {31'h0, sleep_mode}, 32'h1);
    cx(no_operation_op, 1'b0, 1'b0, 16'h0);
    rc("pc", PC_OFS, 32'h502);
    wr(STATUS_OFS, 32'h2);
    chk("wake", {31'h0, sleep_mode}, 32'h0);
    // undefined op flags illegal; last branch of the sweep was taken
    cx(5'h16, 1'b0, 1'b0, 16'h0);
    rc("status", STATUS_OFS, 32'hc);
    wr(STATUS_OFS, 32'h8);
    rc("status", STATUS_OFS, 32'h4);
    for (int i = 0; i < 5; i++) begin
      wr(MEM_ADDR_OFS, 32'(8'h40 + i));
      wr(MEM_DATA_OFS, 32'(8'h11 * (i + 1)));
      wr(MEM_ADDR_OFS, 32'(8'h80 + i));
      wr(MEM_DATA_OFS, 32'hee);
    end
    wr(SRC_OFS, 32'h40);
    wr(DST_OFS, 32'h80);
    wr(COUNT_OFS, 32'h0104);
    wr(PC_OFS, 32'h600);
    mv(block_move_byte_count_op, 1'b1);
    for (int i = 0; i < 4; i++) mc(8'(8'h80 + i), 8'(8'h11 * (i + 1)));
    mc(8'h84, 8'hee);
    rc("src", SRC_OFS, 32'h44);
    rc("dst", DST_OFS, 32'h84);
    rc("count", COUNT_OFS, 32'h0100);
    rc("pc", PC_OFS, 32'h602);
    mv(block_move_byte_count_op, 1'b0);
    rc("src", SRC_OFS, 32'h44);
    rc("pc", PC_OFS, 32'h604);
    mc(8'h84, 8'hee);
    wr(SRC_OFS, 32'h40);
    wr(DST_OFS, 32'h90);
    wr(COUNT_OFS, 32'h2);
    mv(block_move_word_count_op, 1'b1);
    mc(8'h91, 8'h22);
    rc("count", COUNT_OFS, 32'h0);
    rc("unmapped", 8'h3c, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    wrap_up();
  end

  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
endmodule // test_cpu_bitop_branch_sysctl_exec
`default_nettype wire
